// file: include/uart_rx_consts.vh
`ifndef UART_RX_CONSTS_VH
`define UART_RX_CONSTS_VH

// Register byte offsets
`define OFS_RX_STATUS_CONTROL 8'h00
`define OFS_RX_DATA_BUFFER    8'h04
`define OFS_TX_STATUS_CONTROL 8'h08
`define OFS_BAUD_CONTROL      8'h0C
`define OFS_BAUD_DIVISOR_HIGH 8'h10
`define OFS_BAUD_DIVISOR_LOW  8'h14
`define OFS_IRQ_CONTROL       8'h18

// rx_status_control fields
`define BIT_PORT_ENABLE       7
`define BIT_NINE_BIT_RX       6
`define BIT_SINGLE_RX         5
`define BIT_CONT_RX_ENABLE    4
`define BIT_ADDR_FILTER       3
`define BIT_FRAMING_ERROR     2
`define BIT_OVERRUN           1
`define BIT_RX_NINTH          0

// tx_status_control fields
`define BIT_SYNC_MODE         4
`define BIT_BAUD_HIGH_SPEED   2

// baud_control fields
`define BIT_RX_IDLE           6
`define BIT_BAUD_WIDE         3
`define BIT_WAKE_ENABLE       1

// irq_control fields
`define BIT_RX_IRQ_ENABLE     0
`define BIT_RX_IRQ_PRIORITY   1
`define BIT_GLOBAL_IRQ_ENABLE 2
`define BIT_RX_IRQ_FLAG       7

// Reset values
`define RST_BYTE              8'h00
`define RST_WORD              32'h0000_0000

// Oversampling: last tick of a bit, and tick of mid start bit
`define TICK_LAST             4'hF
`define TICK_MID              4'h7
`define PRESCALE_LAST         2'h3

`endif

// file: src/baud_gen.v
`timescale 1ns/1ps
`default_nettype none
module baud_gen
(
	// Clock and reset
	input  wire        mclk,
	input  wire        rst,
	// Control
	input  wire        run,
	input  wire [15:0] divisor,
	input  wire        wide,
	input  wire        high_speed,
	// Oversample enable, sixteen per bit
	output reg         tick
);
`include "uart_rx_consts.vh"

	reg [15:0] cnt_reg;
	reg [1:0]  pre_reg;

	always @(posedge mclk)
	begin
		if (rst || !run)
		begin
			cnt_reg <= 16'h0000;
			pre_reg <= 2'h0;
			tick    <= 1'b0;
		end
		else if (cnt_reg == 16'h0000)
		begin
			cnt_reg <= wide ? divisor : {8'h00, divisor[7:0]};
			// Slow setting with the narrow counter divides a further four
			if (wide || high_speed)
			begin
				tick <= 1'b1;
			end
			else
			begin
				pre_reg <= pre_reg + 2'h1;
				tick    <= (pre_reg == `PRESCALE_LAST);
			end
		end
		else
		begin
			cnt_reg <= cnt_reg - 16'h0001;
			tick    <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: src/rx_fifo2.v
`timescale 1ns/1ps
`default_nettype none
module rx_fifo2
(
	// Clock and reset
	input  wire       mclk,
	input  wire       rst,
	// Write side
	input  wire       push,
	input  wire [9:0] din,
	// Read side
	input  wire       pop,
	output reg  [9:0] dout,
	output wire       empty,
	output wire       full
);
	reg [9:0] mem [0:1];
	reg       wr_ptr_reg;
	reg       rd_ptr_reg;
	reg [1:0] count_reg;

	assign empty = (count_reg == 2'h0);
	assign full  = (count_reg == 2'h2);

	always @(posedge mclk)
	begin
		if (push && !full)
		begin
			mem[wr_ptr_reg] <= din;
		end
		dout <= mem[rd_ptr_reg];
	end

	always @(posedge mclk)
	begin
		if (rst)
		begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end
		else
		begin
			if (push && !full)
			begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop && !empty)
			begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			if ((push && !full) && !(pop && !empty))
			begin
				count_reg <= count_reg + 2'h1;
			end
			else if (!(push && !full) && (pop && !empty))
			begin
				count_reg <= count_reg - 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// file: src/uart_rx_addr_detect_wakeup.v
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_addr_detect_wakeup
(
	// Clock and reset
	input  wire        mclk,
	input  wire        rst,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Serial line and pin ownership
	input  wire        serial_rx_pin,
	output reg         rx_pin_select,
	// Processor power state
	input  wire        sleep,
	// Interrupt request
	output reg         rx_irq,
	output reg         rx_irq_high_prio
);
`include "uart_rx_consts.vh"

	localparam ST_IDLE  = 2'h0;
	localparam ST_START = 2'h1;
	localparam ST_DATA  = 2'h2;
	localparam ST_STOP  = 2'h3;

	// Address match on word offset
	function is_ofs;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			is_ofs = (addr[7:2] == ofs[7:2]);
		end
	endfunction

	// Software state
	reg        port_enable_reg;
	reg        nine_bit_rx_enable_reg;
	reg        single_rx_reg;
	reg        continuous_rx_enable_reg;
	reg        address_filter_enable_reg;
	reg        sync_mode_reg;
	reg        baud_high_speed_reg;
	reg        baud_wide_counter_reg;
	reg        wake_enable_reg;
	reg [7:0]  baud_divisor_high_reg;
	reg [7:0]  baud_divisor_low_reg;
	reg        rx_irq_enable_reg;
	reg        rx_irq_priority_reg;
	reg        global_irq_enable_reg;

	// Hardware flags
	reg        overrun_flag_reg;
	reg        wake_flag_reg;
	reg        wake_seen_reg;

	// Bus pipeline
	reg        pend_reg;
	reg        pend_write_reg;
	reg [7:0]  pend_addr_reg;

	// Line synchroniser and edge history
	reg        rx_meta_reg;
	reg        rx_sync_reg;
	reg        rx_prev_reg;

	// Receiver
	reg [1:0]  state_reg;
	reg [3:0]  tick_cnt_reg;
	reg [3:0]  bit_cnt_reg;
	reg [8:0]  shift_reg;

	wire       tick;
	wire [9:0] fifo_dout;
	wire       fifo_empty;
	wire       fifo_full;

	wire async_on = port_enable_reg && !sync_mode_reg;
	wire wake_active = wake_enable_reg && async_on;
	wire rx_enable = async_on && continuous_rx_enable_reg && !wake_active
		&& !sleep && !overrun_flag_reg;

	wire fall_edge = rx_prev_reg && !rx_sync_reg;
	wire rise_edge = !rx_prev_reg && rx_sync_reg;

	wire bus_take  = hsel && htrans[1] && hready;
	wire wr_cycle  = pend_reg && pend_write_reg;
	wire rd_data   = pend_reg && !pend_write_reg
		&& is_ofs(pend_addr_reg, `OFS_RX_DATA_BUFFER);

	// Character completion
	wire       char_done  = (state_reg == ST_STOP) && tick && (tick_cnt_reg == `TICK_LAST);
	wire [8:0] char_data  = nine_bit_rx_enable_reg ? shift_reg : {1'b0, shift_reg[8:1]};
	wire [3:0] last_bit   = nine_bit_rx_enable_reg ? 4'h8 : 4'h7;
	wire       discard    = address_filter_enable_reg && nine_bit_rx_enable_reg && !char_data[8];
	// all characters pass the filter when filtering is off; a full FIFO drops them
	wire       fifo_push  = char_done && !discard && !fifo_full;
	wire       fifo_pop   = rd_data;

	// flag is pending data or a wake event
	wire       irq_flag   = !fifo_empty || wake_flag_reg;

	wire [7:0] rx_status_val =
	{
		port_enable_reg,
		nine_bit_rx_enable_reg,
		single_rx_reg,
		continuous_rx_enable_reg,
		address_filter_enable_reg,
		// framing error and ninth bit of the oldest character, and overrun flag
		fifo_dout[9] && !fifo_empty,
		overrun_flag_reg,
		fifo_dout[8] && !fifo_empty
	};

	baud_gen u_baud_gen
	(
		.mclk       (mclk),
		.rst        (rst),
		.run        (rx_enable),
		.divisor    ({baud_divisor_high_reg, baud_divisor_low_reg}),
		.wide       (baud_wide_counter_reg),
		.high_speed (baud_high_speed_reg),
		.tick       (tick)
	);

	rx_fifo2 u_rx_fifo2
	(
		.mclk  (mclk),
		.rst   (rst),
		.push  (fifo_push),
		.din   ({~rx_sync_reg, char_data}),
		.pop   (fifo_pop),
		.dout  (fifo_dout),
		.empty (fifo_empty),
		.full  (fifo_full)
	);

	// Line synchroniser
	always @(posedge mclk)
	begin
		if (rst)
		begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
		end
		else
		begin
			rx_meta_reg <= serial_rx_pin;
			rx_sync_reg <= rx_meta_reg;
			rx_prev_reg <= rx_sync_reg;
		end
	end

	// AHB-Lite slave: one wait state per transfer
	always @(posedge mclk)
	begin
		if (rst)
		begin
			pend_reg       <= 1'b0;
			pend_write_reg <= 1'b0;
			pend_addr_reg  <= `RST_BYTE;
			hreadyout      <= 1'b1;
			hresp          <= 1'b0;
			hrdata         <= `RST_WORD;
		end
		else if (pend_reg)
		begin
			pend_reg  <= 1'b0;
			hreadyout <= 1'b1;
			if (!pend_write_reg)
			begin
				hrdata <= `RST_WORD;
				if (is_ofs(pend_addr_reg, `OFS_RX_STATUS_CONTROL))
				begin
					hrdata[7:0] <= rx_status_val;
				end
				else if (is_ofs(pend_addr_reg, `OFS_RX_DATA_BUFFER))
				begin
					hrdata[7:0] <= fifo_empty ? `RST_BYTE : fifo_dout[7:0];
				end
				else if (is_ofs(pend_addr_reg, `OFS_TX_STATUS_CONTROL))
				begin
					hrdata[`BIT_SYNC_MODE]       <= sync_mode_reg;
					hrdata[`BIT_BAUD_HIGH_SPEED] <= baud_high_speed_reg;
				end
				else if (is_ofs(pend_addr_reg, `OFS_BAUD_CONTROL))
				begin
					hrdata[`BIT_RX_IDLE]     <= (state_reg == ST_IDLE);
					hrdata[`BIT_BAUD_WIDE]   <= baud_wide_counter_reg;
					hrdata[`BIT_WAKE_ENABLE] <= wake_enable_reg;
				end
				else if (is_ofs(pend_addr_reg, `OFS_BAUD_DIVISOR_HIGH))
				begin
					hrdata[7:0] <= baud_divisor_high_reg;
				end
				else if (is_ofs(pend_addr_reg, `OFS_BAUD_DIVISOR_LOW))
				begin
					hrdata[7:0] <= baud_divisor_low_reg;
				end
				else if (is_ofs(pend_addr_reg, `OFS_IRQ_CONTROL))
				begin
					hrdata[`BIT_RX_IRQ_ENABLE]     <= rx_irq_enable_reg;
					hrdata[`BIT_RX_IRQ_PRIORITY]   <= rx_irq_priority_reg;
					hrdata[`BIT_GLOBAL_IRQ_ENABLE] <= global_irq_enable_reg;
					hrdata[`BIT_RX_IRQ_FLAG]       <= irq_flag;
				end
			end
		end
		else if (bus_take)
		begin
			pend_reg       <= 1'b1;
			pend_write_reg <= hwrite;
			pend_addr_reg  <= haddr[7:0];
			hreadyout      <= 1'b0;
		end
	end

	// Software registers and hardware flags
	always @(posedge mclk)
	begin
		if (rst)
		begin
			port_enable_reg           <= 1'b0;
			nine_bit_rx_enable_reg    <= 1'b0;
			single_rx_reg             <= 1'b0;
			continuous_rx_enable_reg  <= 1'b0;
			address_filter_enable_reg <= 1'b0;
			sync_mode_reg             <= 1'b0;
			baud_high_speed_reg       <= 1'b0;
			baud_wide_counter_reg     <= 1'b0;
			wake_enable_reg           <= 1'b0;
			baud_divisor_high_reg     <= `RST_BYTE;
			baud_divisor_low_reg      <= `RST_BYTE;
			rx_irq_enable_reg         <= 1'b0;
			rx_irq_priority_reg       <= 1'b0;
			global_irq_enable_reg     <= 1'b0;
			overrun_flag_reg          <= 1'b0;
			wake_flag_reg             <= 1'b0;
			wake_seen_reg             <= 1'b0;
		end
		else
		begin
			if (wr_cycle && is_ofs(pend_addr_reg, `OFS_RX_STATUS_CONTROL))
			begin
				port_enable_reg           <= hwdata[`BIT_PORT_ENABLE];
				nine_bit_rx_enable_reg    <= hwdata[`BIT_NINE_BIT_RX];
				single_rx_reg             <= hwdata[`BIT_SINGLE_RX];
				continuous_rx_enable_reg  <= hwdata[`BIT_CONT_RX_ENABLE];
				address_filter_enable_reg <= hwdata[`BIT_ADDR_FILTER];
			end
			if (wr_cycle && is_ofs(pend_addr_reg, `OFS_TX_STATUS_CONTROL))
			begin
				sync_mode_reg       <= hwdata[`BIT_SYNC_MODE];
				baud_high_speed_reg <= hwdata[`BIT_BAUD_HIGH_SPEED];
			end
			if (wr_cycle && is_ofs(pend_addr_reg, `OFS_BAUD_DIVISOR_HIGH))
			begin
				baud_divisor_high_reg <= hwdata[7:0];
			end
			if (wr_cycle && is_ofs(pend_addr_reg, `OFS_BAUD_DIVISOR_LOW))
			begin
				baud_divisor_low_reg <= hwdata[7:0];
			end
			if (wr_cycle && is_ofs(pend_addr_reg, `OFS_IRQ_CONTROL))
			begin
				rx_irq_enable_reg     <= hwdata[`BIT_RX_IRQ_ENABLE];
				rx_irq_priority_reg   <= hwdata[`BIT_RX_IRQ_PRIORITY];
				global_irq_enable_reg <= hwdata[`BIT_GLOBAL_IRQ_ENABLE];
			end

			// Wake enable: software write, hardware clear wins
			if (wr_cycle && is_ofs(pend_addr_reg, `OFS_BAUD_CONTROL))
			begin
				baud_wide_counter_reg <= hwdata[`BIT_BAUD_WIDE];
				wake_enable_reg       <= hwdata[`BIT_WAKE_ENABLE];
			end
			if (!wake_active)
			begin
				wake_seen_reg <= 1'b0;
			end
			// falling edge is the wake event
			else if (!wake_seen_reg && fall_edge)
			begin
				wake_seen_reg <= 1'b1;
			end
			else if (wake_seen_reg && rise_edge)
			begin
				wake_seen_reg   <= 1'b0;
				wake_enable_reg <= 1'b0;
			end

			if (rd_data)
			begin
				wake_flag_reg <= 1'b0;
			end
			// wake event sets flag, set wins
			if (wake_active && !wake_seen_reg && fall_edge)
			begin
				wake_flag_reg <= 1'b1;
			end

			if (!continuous_rx_enable_reg)
			begin
				overrun_flag_reg <= 1'b0;
			end
			else if (char_done && !discard && fifo_full)
			begin
				overrun_flag_reg <= 1'b1;
			end
		end
	end

	// Receive sequencer on oversample ticks
	always @(posedge mclk)
	begin
		if (rst || !rx_enable)
		begin
			state_reg    <= ST_IDLE;
			tick_cnt_reg <= 4'h0;
			bit_cnt_reg  <= 4'h0;
			shift_reg    <= 9'h000;
		end
		else if (tick)
		begin
			case (state_reg)
				ST_IDLE:
				begin
					tick_cnt_reg <= 4'h0;
					if (!rx_sync_reg)
					begin
						state_reg <= ST_START;
					end
				end
				ST_START:
				begin
					tick_cnt_reg <= tick_cnt_reg + 4'h1;
					if (tick_cnt_reg == `TICK_MID)
					begin
						tick_cnt_reg <= 4'h0;
						bit_cnt_reg  <= 4'h0;
						// Glitch rejection on start bit
						state_reg    <= rx_sync_reg ? ST_IDLE : ST_DATA;
					end
				end
				ST_DATA:
				begin
					tick_cnt_reg <= tick_cnt_reg + 4'h1;
					if (tick_cnt_reg == `TICK_LAST)
					begin
						// LSB first, up to nine bits
						shift_reg   <= {rx_sync_reg, shift_reg[8:1]};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (bit_cnt_reg == last_bit)
						begin
							state_reg <= ST_STOP;
						end
					end
				end
				ST_STOP:
				begin
					tick_cnt_reg <= tick_cnt_reg + 4'h1;
					// low stop sample is a framing error
					if (tick_cnt_reg == `TICK_LAST)
					begin
						state_reg <= ST_IDLE;
					end
				end
				default:
				begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Registered outputs
	always @(posedge mclk)
	begin
		if (rst)
		begin
			rx_pin_select    <= 1'b0;
			rx_irq           <= 1'b0;
			rx_irq_high_prio <= 1'b0;
		end
		else
		begin
			rx_pin_select    <= async_on;
			rx_irq           <= irq_flag && rx_irq_enable_reg && global_irq_enable_reg;
			rx_irq_high_prio <= irq_flag && rx_irq_enable_reg && global_irq_enable_reg
				&& rx_irq_priority_reg;
		end
	end
endmodule
`default_nettype wire

// file: verification/uart_rx_addr_detect_wakeup_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_consts.vh"
module uart_rx_sva
(
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Line and outputs
	input wire logic        serial_rx_pin,
	input wire logic        rx_pin_select,
	input wire logic        sleep,
	input wire logic        rx_irq
);
	logic       wr_ph;
	logic       rd_ph;
	logic       wk_sh;
	logic       line_d;
	logic [7:0] ph_ofs;
	logic [7:0] rs_sh;
	logic [7:0] tx_sh;
	logic [7:0] ic_sh;
	wire taken = hsel && htrans[1] && hready;
	wire pin_ok = rs_sh[`BIT_PORT_ENABLE] && !tx_sh[`BIT_SYNC_MODE];
	wire irq_on = ic_sh[`BIT_RX_IRQ_ENABLE] && ic_sh[`BIT_GLOBAL_IRQ_ENABLE];

	// Shadow of control bits written over the bus
	always @(posedge mclk)
	begin
		line_d <= serial_rx_pin;
		ph_ofs <= haddr[7:0];
		wr_ph <= !rst && taken && hwrite;
		rd_ph <= !rst && taken && !hwrite;
		if (rst)
		begin
			rs_sh <= 8'h00;
			tx_sh <= 8'h00;
			ic_sh <= 8'h00;
			wk_sh <= 1'b0;
		end
		else
		begin
			if (wr_ph && ph_ofs == `OFS_RX_STATUS_CONTROL)
				rs_sh <= hwdata[7:0];
			if (wr_ph && ph_ofs == `OFS_TX_STATUS_CONTROL)
				tx_sh <= hwdata[7:0];
			if (wr_ph && ph_ofs == `OFS_IRQ_CONTROL)
				ic_sh <= hwdata[7:0];
			if (wr_ph && ph_ofs == `OFS_BAUD_CONTROL)
				wk_sh <= hwdata[`BIT_WAKE_ENABLE];
			else if (serial_rx_pin && !line_d)
				wk_sh <= 1'b0;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence s_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence s_quiet;
		sleep && !wk_sh && !wr_ph;
	endsequence

	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay)
		else $error("bus response not okay");
	property p_wait;
		taken |=> s_wait;
	endproperty
	a_wait: assert property (p_wait)
		else $error("data phase not one wait state");
	property p_rdata;
		$changed(hrdata) |-> $past(rd_ph);
	endproperty
	a_rdata: assert property (p_rdata)
		else $error("read data changed outside a read");
	property p_irq_gate;
		rx_irq |-> $past(irq_on);
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt without enables");
	property p_pin;
		rx_pin_select |-> pin_ok || $past(pin_ok);
	endproperty
	a_pin: assert property (p_pin)
		else $error("pin owned outside async mode");
	property p_pin_on;
		pin_ok && $past(pin_ok) |-> rx_pin_select;
	endproperty
	a_pin_on: assert property (p_pin_on)
		else $error("pin not owned in async mode");
	property p_wake;
		$fell(serial_rx_pin) && wk_sh && pin_ok && irq_on |-> ##[1:8] rx_irq;
	endproperty
	a_wake: assert property (p_wake)
		else $error("no interrupt on wake edge");
	property p_sleep;
		s_quiet ##1 s_quiet |=> !$rose(rx_irq);
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("character received while asleep");
endmodule
`default_nettype wire

// file: verification/serial_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model
#(
	parameter int BIT_CLKS = 16
)
(
	input  wire logic mclk,
	output var logic  line
);
	initial line = 1'b1;
	// Level for whole bit times
	task hold(input logic lvl, input int bits);
		line <= lvl;
		repeat (bits * BIT_CLKS) @(posedge mclk);
	endtask
	// Start, data LSB first, stop, one idle bit
	task send(input logic [8:0] d, input int nbits, input logic stop);
		int i;
		hold(1'b0, 1);
		for (i = 0; i < nbits; i++)
			hold(d[i], 1);
		hold(stop, 1);
		hold(1'b1, 1);
	endtask
	task break_low;
		hold(1'b0, 13);
	endtask
	task break_end;
		hold(1'b1, 4);
	endtask
endmodule
`default_nettype wire

// file: verification/tb_uart_rx_addr_detect_wakeup.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_consts.vh"
module tb_uart_rx_addr_detect_wakeup;
	localparam logic [7:0] o_rs = `OFS_RX_STATUS_CONTROL;
	localparam logic [7:0] o_rd = `OFS_RX_DATA_BUFFER;
	localparam logic [7:0] o_tx = `OFS_TX_STATUS_CONTROL;
	localparam logic [7:0] o_bc = `OFS_BAUD_CONTROL;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic        sleep = 1'b0;
	logic [31:0] rd;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	wire         line;
	wire         rx_pin_select;
	wire         rx_irq;
	wire         rx_irq_high_prio;
	int          miscompares = 0;
	int          n_checks = 0;

	always #5 mclk = ~mclk;

	uart_rx_addr_detect_wakeup DUT (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.serial_rx_pin(line), .rx_pin_select(rx_pin_select), .sleep(sleep),
		.rx_irq(rx_irq), .rx_irq_high_prio(rx_irq_high_prio));
	serial_tx_model u_tx (.mclk(mclk), .line(line));

	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string what, input logic [7:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== {24'h00_0000, exp})
		begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask
	task chm(input string what, input logic [7:0] exp);
		chk(what, exp, rd & 32'h0000_00FE);
	endtask
	// Waits on the bus answer, bounded
	task wait_rdy;
		int n;
		for (n = 0; n == 0 || hreadyout !== 1'b1; n++)
		begin
			if (n > 20)
			begin
				chk("hreadyout", 8'h01, 32'(hreadyout));
				report_and_stop;
			end
			@(posedge mclk);
		end
	endtask
	task xfer(input logic [7:0] a, input logic w, input logic [7:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'b10;
		wait_rdy;
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, wd};
		wait_rdy;
		rd = hrdata;
	endtask
	task wait_irq(input logic lvl);
		int n;
		for (n = 0; rx_irq !== lvl; n++)
		begin
			if (n > 400)
			begin
				chk("rx_irq", 8'(lvl), 32'(rx_irq));
				report_and_stop;
			end
			@(posedge mclk);
		end
	endtask

	task t_reset;
		int i;
		chk("rx_pin_select", 8'h00, 32'(rx_pin_select));
		for (i = 0; i < 8; i++)
		begin
			xfer(8'(i * 4), 1'b0, 8'h00);
			chk("reset value", (i == 3) ? 8'h40 : 8'h00, rd);
		end
		$display("t_reset done");
	endtask
	task t_config;
		xfer(o_tx, 1'b1, 8'h10);
		xfer(o_bc, 1'b1, 8'h08);
		xfer(`OFS_BAUD_DIVISOR_LOW, 1'b1, 8'h00);
		xfer(`OFS_IRQ_CONTROL, 1'b1, 8'h07);
		xfer(o_rs, 1'b1, 8'h90);
		chk("pin in sync mode", 8'h00, 32'(rx_pin_select));
		xfer(o_tx, 1'b1, 8'h00);
		xfer(o_bc, 1'b0, 8'h00);
		chk("pin in async mode", 8'h01, 32'(rx_pin_select));
		chk("baud control", 8'h48, rd);
		$display("t_config done");
	endtask
	task t_eight;
		u_tx.send(9'h0A5, 8, 1'b1);
		u_tx.send(9'h03C, 8, 1'b0);
		wait_irq(1'b1);
		xfer(o_rs, 1'b0, 8'h00);
		chm("status", 8'h90);
		chk("high priority", 8'h01, 32'(rx_irq_high_prio));
		xfer(o_rd, 1'b0, 8'h00);
		chk("data", 8'hA5, rd);
		xfer(o_rs, 1'b0, 8'h00);
		chm("framing", 8'h94);
		xfer(o_rd, 1'b0, 8'h00);
		chk("data", 8'h3C, rd);
		wait_irq(1'b0);
		$display("t_eight done");
	endtask
	task t_nine;
		xfer(o_rs, 1'b1, 8'hD8);
		u_tx.send(9'h033, 9, 1'b1);
		chk("filtered irq", 8'h00, 32'(rx_irq));
		u_tx.send(9'h15A, 9, 1'b1);
		wait_irq(1'b1);
		xfer(o_rs, 1'b0, 8'h00);
		chk("ninth bit", 8'hD9, rd);
		xfer(o_rd, 1'b0, 8'h00);
		chk("address", 8'h5A, rd);
		xfer(o_rs, 1'b1, 8'hD0);
		u_tx.send(9'h077, 9, 1'b1);
		wait_irq(1'b1);
		xfer(o_rs, 1'b0, 8'h00);
		chk("ninth bit", 8'hD0, rd);
		xfer(o_rd, 1'b0, 8'h00);
		chk("data", 8'h77, rd);
		$display("t_nine done");
	endtask
	task t_overrun;
		int k;
		xfer(o_rs, 1'b1, 8'h90);
		for (k = 0; k < 3; k++)
			u_tx.send(9'(17 + k), 8, 1'b1);
		xfer(o_rs, 1'b0, 8'h00);
		chm("overrun", 8'h92);
		xfer(o_rs, 1'b1, 8'h80);
		xfer(o_rs, 1'b0, 8'h00);
		chm("error cleared", 8'h80);
		xfer(o_rd, 1'b0, 8'h00);
		chk("first", 8'h11, rd);
		xfer(o_rd, 1'b0, 8'h00);
		chk("second", 8'h12, rd);
		wait_irq(1'b0);
		xfer(o_rs, 1'b1, 8'h90);
		$display("t_overrun done");
	endtask
	task t_sleep;
		sleep <= 1'b1;
		u_tx.send(9'h055, 8, 1'b1);
		chk("asleep irq", 8'h00, 32'(rx_irq));
		sleep <= 1'b0;
		xfer(o_rs, 1'b0, 8'h00);
		chm("asleep status", 8'h90);
		$display("t_sleep done");
	endtask
	task t_wake;
		xfer(o_bc, 1'b1, 8'h0A);
		sleep <= 1'b1;
		u_tx.break_low;
		chk("wake irq", 8'h01, 32'(rx_irq));
		sleep <= 1'b0;
		xfer(o_bc, 1'b0, 8'h00);
		chk("wake held", 8'h02, rd & 32'h0000_0002);
		u_tx.break_end;
		xfer(o_bc, 1'b0, 8'h00);
		chk("wake cleared", 8'h00, rd & 32'h0000_0002);
		// Value read here is dummy and dropped
		xfer(o_rd, 1'b0, 8'h00);
		wait_irq(1'b0);
		xfer(o_rs, 1'b0, 8'h00);
		chm("no break char", 8'h90);
		u_tx.send(9'h0C3, 8, 1'b1);
		wait_irq(1'b1);
		xfer(o_rd, 1'b0, 8'h00);
		chk("after wake", 8'hC3, rd);
		$display("t_wake done");
	endtask
	// Narrow divisor, high byte ignored, fast setting
	task t_narrow;
		xfer(o_bc, 1'b1, 8'h00);
		xfer(o_tx, 1'b1, 8'h04);
		xfer(`OFS_BAUD_DIVISOR_HIGH, 1'b1, 8'hA5);
		xfer(`OFS_BAUD_DIVISOR_HIGH, 1'b0, 8'h00);
		chk("divisor high", 8'hA5, rd);
		xfer(o_tx, 1'b0, 8'h00);
		chk("tx status", 8'h04, rd);
		u_tx.send(9'h05A, 8, 1'b1);
		wait_irq(1'b1);
		xfer(o_rd, 1'b0, 8'h00);
		chk("narrow data", 8'h5A, rd);
		$display("t_narrow done");
	endtask

	initial
	begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset;
		t_config;
		t_eight;
		t_nine;
		t_overrun;
		t_sleep;
		t_wake;
		t_narrow;
		report_and_stop;
	end
endmodule

bind uart_rx_addr_detect_wakeup uart_rx_sva u_sva (.mclk, .rst, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .serial_rx_pin,
	.rx_pin_select, .sleep, .rx_irq);
`default_nettype wire
